// >>> design/dma_pkg.sv
// package: register map, field layout and state codes of the dma channel block
package dma_pkg;
   // register byte addresses (apb)
   localparam logic [11:0] addr_options = 12'h000;
   localparam logic [11:0] addr_src = 12'h004;
   localparam logic [11:0] addr_dst = 12'h008;
   localparam logic [11:0] addr_counts = 12'h00C;
   localparam logic [11:0] addr_steps = 12'h010;
   localparam logic [11:0] addr_link = 12'h014;
   localparam logic [11:0] addr_trigger = 12'h018;
   localparam logic [11:0] addr_chain_event = 12'h01C;
   localparam logic [11:0] addr_region_sel = 12'h020;
   localparam logic [11:0] addr_region_chan_mask = 12'h024;
   localparam logic [11:0] addr_region_quick_mask = 12'h028;
   localparam logic [11:0] addr_ctl_status = 12'h02C;
   localparam logic [11:0] addr_eng_status = 12'h030;
   localparam logic [11:0] addr_error_record = 12'h034;
   localparam logic [11:0] addr_error_enable = 12'h038;
   localparam logic [11:0] addr_set_base = 12'h100;
   localparam logic [11:0] addr_set_span = 12'h100;
   // options word fields
   localparam int opt_src_fixed = 0;
   localparam int opt_dst_fixed = 1;
   localparam int opt_frame_sync = 2;
   localparam int opt_hold = 3;
   localparam int opt_width_lo = 8;
   localparam int opt_code_lo = 12;
   localparam int opt_final_chain = 22;
   // controller status fields
   localparam int cs_event = 0;
   localparam int cs_quick = 1;
   localparam int cs_request = 2;
   localparam int cs_wstat = 3;
   localparam int cs_ctl = 4;
   localparam int cs_queue_lo = 16;
   localparam int cs_count_lo = 8;
   // engine status fields
   localparam int es_prog = 0;
   localparam int es_src = 1;
   localparam int es_wstat = 2;
   localparam int es_buf_lo = 4;
   // geometry
   localparam int num_regions = 8;
   localparam int num_sets = 16;
   localparam int num_chan = 64;
   localparam int words_per_set = 6;
   // error bits
   localparam int err_bad_link = 0;
   localparam int err_bad_region = 1;
   localparam logic [31:0] zero32 = 32'h0000_0000;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_move = 2'b01,
      st_row_end = 2'b10,
      st_done = 2'b11
   } state_t;
endpackage : dma_pkg

// >>> design/dma_set_memory_a_link_chain_status.sv
// dma channel engine with linking, chaining, regions and status registers
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module dma_set_memory_a_link_chain_status (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // transfer port toward memory and peripherals
   input wire logic sync_event,
   output logic xfer_valid,
   output logic [31:0] xfer_src_addr,
   output logic [31:0] xfer_dst_addr,
   output logic [2:0] xfer_width,
   input wire logic xfer_ready,
   // channel number of this engine
   input wire logic [5:0] chan_id
);
   //////////////////////////////////////////////////////////////////////////////
   typedef logic [31:0] set_t [dma_pkg::words_per_set];
   typedef struct packed {
      logic [31:0] options;
      logic [31:0] src;
      logic [31:0] dst;
      logic [31:0] counts;
      logic [31:0] steps;
      logic [31:0] link;
      logic [31:0] cur_src;
      logic [31:0] cur_dst;
      logic [31:0] row_src;
      logic [31:0] row_dst;
      logic [15:0] a_left;
      logic [15:0] b_left;
      logic [63:0] chain_event;
      logic [2:0] region;
      logic [7:0][63:0] chan_mask;
      logic [7:0][7:0] quick_mask;
      logic [31:0] err_rec;
      logic [31:0] err_en;
      logic [3:0] comp_count;
      logic pend_trig;
      logic [31:0] rdata;
      logic [dma_pkg::num_sets-1:0][5:0][31:0] sets;
      dma_pkg::state_t state;
   } state_s_t;
   state_s_t r;
   state_s_t next_r;
   logic sync_meta;
   logic sync_q;
   logic sync_d;

   // row step applied to an address, stepping or fixed
   function automatic logic [31:0] step_addr(input logic [31:0] a, input logic fixed, input logic [31:0] n);
      step_addr = fixed ? a : a + n;
   endfunction : step_addr

   // width field decoded to bytes per access
   function automatic logic [31:0] width_bytes(input logic [2:0] w);
      width_bytes = 32'h0000_0001 << w;
   endfunction : width_bytes

   // fixed access width in bytes
   function automatic logic [31:0] zero_guard(input logic [2:0] w);
      zero_guard = width_bytes(w);
   endfunction : zero_guard

   //////////////////////////////////////////////////////////////////////////////
   // external trigger pin synchroniser and edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync_meta <= 1'b0;
         sync_q <= 1'b0;
         sync_d <= 1'b0;
      end else begin
         sync_meta <= sync_event;
         sync_q <= sync_meta;
         sync_d <= sync_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   logic wr;
   logic rd;
   logic set_hit;
   logic [3:0] set_idx;
   logic [2:0] word_idx;
   logic fixed_s;
   logic fixed_d;
   logic frame;
   logic [2:0] fwidth;
   logic [5:0] code;
   logic in_region;
   logic trig;
   logic [31:0] ebytes_s;
   logic [31:0] ebytes_d;
   logic [11:0] set_off;
   logic trig_raw;
   logic [15:0] abytes;
   logic [31:0] last_s;
   logic [31:0] last_d;

   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign set_off = paddr - dma_pkg::addr_set_base;
   assign set_hit = paddr >= dma_pkg::addr_set_base;
   assign set_idx = set_off[11:8];
   assign word_idx = set_off[4:2];
   assign fixed_s = r.options[dma_pkg::opt_src_fixed];
   assign fixed_d = r.options[dma_pkg::opt_dst_fixed];
   assign frame = r.options[dma_pkg::opt_frame_sync];
   assign fwidth = r.options[dma_pkg::opt_width_lo +: 3];
   assign code = r.options[dma_pkg::opt_code_lo +: 6];
   // region membership gates triggers
   assign in_region = r.chan_mask[r.region][chan_id];
   // bytes per access: fixed width or unit step
   assign ebytes_s = fixed_s ? zero_guard(fwidth) : 32'h0000_0001;
   assign ebytes_d = fixed_d ? zero_guard(fwidth) : 32'h0000_0001;
   // any trigger source, before the region gate
   assign trig_raw = (sync_q & ~sync_d) | r.pend_trig | r.chain_event[chan_id];
   assign trig = trig_raw & in_region;
   // bytes moved per access and counted off the row
   assign abytes = (fixed_s | fixed_d) ? 16'(zero_guard(fwidth)) : 16'h0001;
   // row mode base: last byte of the row; a fixed side stays put
   assign last_s = fixed_s ? r.cur_src : r.cur_src - ebytes_s;
   assign last_d = fixed_d ? r.cur_dst : r.cur_dst - ebytes_d;

   //////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r = r;
      // register writes; status addresses fall through untouched
      if (wr && !set_hit) begin
         case (paddr)
            dma_pkg::addr_options: next_r.options = pwdata;
            dma_pkg::addr_src: next_r.src = pwdata;
            dma_pkg::addr_dst: next_r.dst = pwdata;
            dma_pkg::addr_counts: next_r.counts = pwdata;
            dma_pkg::addr_steps: next_r.steps = pwdata;
            dma_pkg::addr_link: next_r.link = pwdata;
            dma_pkg::addr_trigger: next_r.pend_trig = pwdata[0];
            dma_pkg::addr_chain_event: next_r.chain_event = r.chain_event & ~{32'h0000_0000, pwdata};
            dma_pkg::addr_region_sel: next_r.region = pwdata[2:0];
            dma_pkg::addr_region_chan_mask: next_r.chan_mask[r.region] = {32'h0000_0000, pwdata};
            dma_pkg::addr_region_quick_mask: next_r.quick_mask[r.region] = pwdata[7:0];
            dma_pkg::addr_error_record: next_r.err_rec = r.err_rec & ~pwdata;
            dma_pkg::addr_error_enable: next_r.err_en = pwdata;
            default: next_r.err_rec = r.err_rec;
         endcase
      end else if (wr && set_hit && word_idx < 3'(dma_pkg::words_per_set)) begin
         next_r.sets[set_idx][word_idx] = pwdata;
      end
      // engine
      case (r.state)
         dma_pkg::st_idle: begin
            if (trig) begin
               next_r.pend_trig = 1'b0;
               next_r.chain_event[chan_id] = 1'b0;
               if (r.a_left == 16'h0000) begin
                  next_r.cur_src = r.src;
                  next_r.cur_dst = r.dst;
                  next_r.row_src = r.src;
                  next_r.row_dst = r.dst;
                  next_r.a_left = r.counts[15:0];
                  next_r.b_left = r.counts[31:16];
                  // one completion request per block, not per row
                  next_r.comp_count = r.comp_count + 4'h1;
               end
               next_r.state = dma_pkg::st_move;
            end else if (trig_raw) begin
               // refused trigger dropped so a cleared error stays clear
               next_r.pend_trig = 1'b0;
               next_r.chain_event[chan_id] = 1'b0;
               if (r.err_en[dma_pkg::err_bad_region]) begin
                  next_r.err_rec[dma_pkg::err_bad_region] = 1'b1;
               end
            end
         end
         dma_pkg::st_move: begin
            if (xfer_ready) begin
               // fixed address held, stepping address advances
               next_r.cur_src = step_addr(r.cur_src, fixed_s, ebytes_s);
               next_r.cur_dst = step_addr(r.cur_dst, fixed_d, ebytes_d);
               if (r.a_left <= abytes) begin
                  next_r.a_left = 16'h0000;
                  next_r.state = dma_pkg::st_row_end;
               end else begin
                  next_r.a_left = r.a_left - abytes;
               end
            end
         end
         dma_pkg::st_row_end: begin
            // row step base depends on sync mode
            if (frame) begin
               next_r.cur_src = step_addr(r.row_src, fixed_s, {{16{r.steps[15]}}, r.steps[15:0]});
               next_r.cur_dst = step_addr(r.row_dst, fixed_d, {{16{r.steps[31]}}, r.steps[31:16]});
            end else begin
               next_r.cur_src = step_addr(last_s, fixed_s, {{16{r.steps[15]}}, r.steps[15:0]});
               next_r.cur_dst = step_addr(last_d, fixed_d, {{16{r.steps[31]}}, r.steps[31:16]});
            end
            next_r.row_src = next_r.cur_src;
            next_r.row_dst = next_r.cur_dst;
            if (r.b_left <= 16'h0001) begin
               next_r.b_left = 16'h0000;
               next_r.state = dma_pkg::st_done;
            end else begin
               next_r.b_left = r.b_left - 16'h0001;
               next_r.a_left = r.counts[15:0];
               // frame mode runs on; row mode waits for next trigger
               next_r.state = frame ? dma_pkg::st_move : dma_pkg::st_idle;
            end
         end
         dma_pkg::st_done: begin
            next_r.comp_count = r.comp_count - 4'h1;
            // completion code selects chain event bit
            if (r.options[dma_pkg::opt_final_chain]) begin
               next_r.chain_event[code] = 1'b1;
            end
            // link reload unless held; no trigger raised
            if (!r.options[dma_pkg::opt_hold]) begin
               if (r.link[15:0] >= 16'(dma_pkg::num_sets) && r.link[15:0] != 16'hFFFF) begin
                  if (r.err_en[dma_pkg::err_bad_link]) begin
                     next_r.err_rec[dma_pkg::err_bad_link] = 1'b1;
                  end
               end else if (r.link[15:0] != 16'hFFFF) begin
                  next_r.options = r.sets[r.link[3:0]][0];
                  next_r.src = r.sets[r.link[3:0]][1];
                  next_r.dst = r.sets[r.link[3:0]][2];
                  next_r.counts = r.sets[r.link[3:0]][3];
                  next_r.steps = r.sets[r.link[3:0]][4];
                  next_r.link = r.sets[r.link[3:0]][5];
               end
            end
            next_r.a_left = 16'h0000;
            next_r.state = dma_pkg::st_idle;
         end
         default: next_r.state = dma_pkg::st_idle;
      endcase
      // read data capture in setup cycle
      if (rd) begin
         case (paddr)
            dma_pkg::addr_options: next_r.rdata = r.options;
            dma_pkg::addr_src: next_r.rdata = r.src;
            dma_pkg::addr_dst: next_r.rdata = r.dst;
            dma_pkg::addr_counts: next_r.rdata = r.counts;
            dma_pkg::addr_steps: next_r.rdata = r.steps;
            dma_pkg::addr_link: next_r.rdata = r.link;
            dma_pkg::addr_chain_event: next_r.rdata = r.chain_event[31:0];
            dma_pkg::addr_region_sel: next_r.rdata = {29'h000_0000, r.region};
            dma_pkg::addr_region_chan_mask: next_r.rdata = r.chan_mask[r.region][31:0];
            dma_pkg::addr_region_quick_mask: next_r.rdata = {24'h00_0000, r.quick_mask[r.region]};
            dma_pkg::addr_ctl_status: begin
               next_r.rdata = dma_pkg::zero32;
               next_r.rdata[dma_pkg::cs_event] = trig;
               next_r.rdata[dma_pkg::cs_quick] = 1'b0;
               next_r.rdata[dma_pkg::cs_request] = r.state == dma_pkg::st_move;
               next_r.rdata[dma_pkg::cs_wstat] = r.comp_count != 4'h0;
               next_r.rdata[dma_pkg::cs_ctl] = r.state != dma_pkg::st_idle;
               next_r.rdata[dma_pkg::cs_count_lo +: 4] = r.comp_count;
               next_r.rdata[dma_pkg::cs_queue_lo] = r.state != dma_pkg::st_idle;
            end
            dma_pkg::addr_eng_status: begin
               next_r.rdata = dma_pkg::zero32;
               next_r.rdata[dma_pkg::es_prog] = r.state != dma_pkg::st_idle;
               next_r.rdata[dma_pkg::es_src] = r.state == dma_pkg::st_move;
               next_r.rdata[dma_pkg::es_wstat] = r.state == dma_pkg::st_done;
               next_r.rdata[dma_pkg::es_buf_lo +: 3] = {2'b00, xfer_valid & ~xfer_ready};
            end
            dma_pkg::addr_error_record: next_r.rdata = r.err_rec & r.err_en;
            dma_pkg::addr_error_enable: next_r.rdata = r.err_en;
            default: next_r.rdata = (set_hit && word_idx < 3'(dma_pkg::words_per_set)) ?
               r.sets[set_idx][word_idx] : dma_pkg::zero32;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   assign prdata = r.rdata;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign xfer_valid = r.state == dma_pkg::st_move;
   assign xfer_src_addr = r.cur_src;
   assign xfer_dst_addr = r.cur_dst;
   assign xfer_width = fwidth;
endmodule : dma_set_memory_a_link_chain_status

// >>> tb/endpoint_model.sv
// endpoint model: memory or peripheral side of the transfer port
`timescale 1ns/1ps
module endpoint_model (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // access port
   input wire logic xfer_valid,
   input wire logic slow,
   output logic xfer_ready
);
   logic phase;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) phase <= 1'b0;
      else phase <= ~phase;
   end
   // accepts fixed and stepping accesses alike; stalls every other cycle when slow
   assign xfer_ready = xfer_valid && (!slow || phase);
endmodule : endpoint_model

// >>> tb/dma_chk_sva.sv
// checker: addressing, access width and bus answer of the dma channel block
`timescale 1ns/1ps
module dma_chk (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input logic pready,
   input logic pslverr,
   // transfer port
   input logic xfer_valid,
   input logic [31:0] xfer_src_addr,
   input logic [31:0] xfer_dst_addr,
   input logic [2:0] xfer_width,
   input wire logic xfer_ready
);
   logic [31:0] channel_options_word;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) channel_options_word <= 32'h0000_0000;
      else if (psel && penable && pwrite && paddr == dma_pkg::addr_options) channel_options_word <= pwdata;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_width; xfer_valid |-> xfer_width == channel_options_word[10:8]; endproperty
   a_width: assert property (p_width) else $error("access width differs from options");
   property p_src_fixed; xfer_valid && channel_options_word[0] && $past(xfer_valid) |-> xfer_src_addr == $past(xfer_src_addr); endproperty
   a_src_fixed: assert property (p_src_fixed) else $error("fixed source moved");
   property p_dst_fixed; xfer_valid && channel_options_word[1] && $past(xfer_valid) |-> $stable(xfer_dst_addr); endproperty
   a_dst_fixed: assert property (p_dst_fixed) else $error("fixed destination moved");
   property p_src_step; (xfer_valid && xfer_ready && !channel_options_word[0]) ##1 xfer_valid |-> xfer_src_addr == $past(xfer_src_addr) + 32'h0000_0001; endproperty
   a_src_step: assert property (p_src_step) else $error("source did not step");
   property p_dst_step; (xfer_valid && xfer_ready && !channel_options_word[1]) ##1 xfer_valid |-> xfer_dst_addr == $past(xfer_dst_addr) + 32'h0000_0001; endproperty
   a_dst_step: assert property (p_dst_step) else $error("destination did not step");
   property p_stall; xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_src_addr) && $stable(xfer_dst_addr); endproperty
   a_stall: assert property (p_stall) else $error("access dropped while stalled");
   property p_bus; psel && penable |-> pready && !pslverr; endproperty
   a_bus: assert property (p_bus) else $error("apb access refused");
   property p_reset; $fell(reset) |-> !xfer_valid [*2]; endproperty
   a_reset: assert property (p_reset) else $error("move started without trigger");
   c_stall: cover property (xfer_valid && !xfer_ready);
   c_fixed: cover property (xfer_valid && channel_options_word[0] && channel_options_word[1]);
   c_frame: cover property (xfer_valid && channel_options_word[2]);
endmodule : dma_chk
bind dma_set_memory_a_link_chain_status dma_chk dma_chk_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .xfer_valid(xfer_valid),
   .xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr), .xfer_width(xfer_width), .xfer_ready(xfer_ready));

// >>> tb/dma_set_memory_a_link_chain_status_tb.sv
// testbench: registers, row stepping, fixed mode, linking, chaining and regions
`timescale 1ns/1ps
module dma_set_memory_a_link_chain_status_tb;
   logic clk, reset, psel, penable, pwrite, sync_event, slow, pready, pslverr, xfer_valid, xfer_ready;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, xfer_src_addr, xfer_dst_addr, rd;
   logic [2:0] xfer_width;
   logic [31:0] src_q[$];
   logic [31:0] dst_q[$];
   int num_errors = 0;
   int checks_done = 0;
   dma_set_memory_a_link_chain_status dma_set_memory_a_link_chain_status_inst (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sync_event(sync_event), .xfer_valid(xfer_valid), .xfer_src_addr(xfer_src_addr),
      .xfer_dst_addr(xfer_dst_addr), .xfer_width(xfer_width), .xfer_ready(xfer_ready), .chan_id(6'h05));
   endpoint_model endpoint_model_inst (.clk(clk), .reset(reset), .xfer_valid(xfer_valid), .slow(slow),
      .xfer_ready(xfer_ready));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // record every accepted access
   always @(posedge clk) begin
      if (xfer_valid === 1'b1 && xfer_ready === 1'b1) begin
         src_q.push_back(xfer_src_addr);
         dst_q.push_back(xfer_dst_addr);
      end
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic load(input logic [11:0] b, input logic [31:0] o, s, d, c, st, l);
      apb(b, 1'b1, o);
      apb(b + 12'h004, 1'b1, s);
      apb(b + 12'h008, 1'b1, d);
      apb(b + 12'h00C, 1'b1, c);
      apb(b + 12'h010, 1'b1, st);
      apb(b + 12'h014, 1'b1, l);
      src_q.delete();
      dst_q.delete();
   endtask : load
   task automatic wait_n(input int n);
      for (int i = 0; i < 400 && src_q.size() < n; i++) @(posedge clk);
      repeat (20) @(posedge clk);
      check("access count", 32'(src_q.size()), 32'(n));
   endtask : wait_n
   task automatic t_regs();
      apb(dma_pkg::addr_ctl_status, 1'b0, 0);
      check("controller status", rd, 0);
      apb(dma_pkg::addr_ctl_status, 1'b1, 32'hFFFF_FFFF);
      apb(dma_pkg::addr_ctl_status, 1'b0, 0);
      check("controller status", rd, 0);
      apb(dma_pkg::addr_eng_status, 1'b1, 32'hFFFF_FFFF);
      apb(dma_pkg::addr_eng_status, 1'b0, 0);
      check("engine status", rd, 0);
      apb(dma_pkg::addr_options, 1'b1, 32'h0040_530B);
      apb(dma_pkg::addr_options, 1'b0, 0);
      check("options", rd, 32'h0040_530B);
      apb(12'h040, 1'b0, 0);
      check("unmapped", rd, 0);
      apb(dma_pkg::addr_region_chan_mask, 1'b1, 32'h0000_0020);
      $display("done registers");
   endtask : t_regs
   task automatic t_rows(input logic frame);
      logic [31:0] s0, d0;
      slow <= frame;
      // global addresses only
      load(12'h000, {29'h0, frame, 2'b00}, 32'h0000_1000, 32'h0000_2000, 32'h0002_0003, 32'h0020_0010, 32'h0000_FFFF);
      apb(dma_pkg::addr_trigger, 1'b1, 1);
      wait_n(frame ? 6 : 3);
      if (!frame) apb(dma_pkg::addr_trigger, 1'b1, 1);
      wait_n(6);
      s0 = frame ? 32'h0000_1010 : 32'h0000_1012;
      d0 = frame ? 32'h0000_2020 : 32'h0000_2022;
      for (int i = 0; i < 6; i++) begin
         check("src addr", src_q[i], (i < 3) ? 32'h0000_1000 + 32'(i) : s0 + 32'(i - 3));
         check("dst addr", dst_q[i], (i < 3) ? 32'h0000_2000 + 32'(i) : d0 + 32'(i - 3));
      end
      $display("done rows frame=%0d", frame);
   endtask : t_rows
   task automatic t_fixed();
      slow <= 1'b1;
      load(12'h000, 32'h0000_0103, 32'h0000_5000, 32'h0000_6000, 32'h0001_0004, 0, 32'h0000_FFFF);
      sync_event <= 1'b1;
      repeat (5) @(posedge clk);
      sync_event <= 1'b0;
      wait_n(2);
      check("fixed src", src_q[1], 32'h0000_5000);
      check("fixed dst", dst_q[1], 32'h0000_6000);
      slow <= 1'b0;
      $display("done fixed");
   endtask : t_fixed
   task automatic t_link(input logic hold);
      load(12'h200, 0, 32'h0000_7000, 32'h0000_7100, 32'h0001_0002, 0, 32'h0000_FFFF);
      load(12'h000, {28'h0, hold, 3'b000}, 32'h0000_3000, 32'h0000_3100, 32'h0001_0002, 0, 32'h0000_0001);
      apb(dma_pkg::addr_trigger, 1'b1, 1);
      wait_n(2);
      apb(dma_pkg::addr_src, 1'b0, 0);
      check("src after completion", rd, hold ? 32'h0000_3000 : 32'h0000_7000);
      apb(dma_pkg::addr_trigger, 1'b1, 1);
      wait_n(4);
      check("second block src", src_q[2], hold ? 32'h0000_3000 : 32'h0000_7000);
      $display("done link hold=%0d", hold);
   endtask : t_link
   task automatic t_chain();
      load(12'h300, 32'h0040_9000, 32'h0000_8000, 32'h0000_8100, 32'h0001_0002, 0, 32'h0000_FFFF);
      load(12'h000, 32'h0040_5000, 32'h0000_3000, 32'h0000_3100, 32'h0001_0002, 0, 32'h0000_0002);
      apb(dma_pkg::addr_trigger, 1'b1, 1);
      wait_n(4);
      check("chained src", src_q[2], 32'h0000_8000);
      apb(dma_pkg::addr_chain_event, 1'b0, 0);
      check("chain event", rd & 32'h0000_0200, 32'h0000_0200);
      apb(dma_pkg::addr_chain_event, 1'b1, 32'h0000_0200);
      apb(dma_pkg::addr_chain_event, 1'b0, 0);
      check("chain cleared", rd & 32'h0000_0200, 0);
      $display("done chain");
   endtask : t_chain
   task automatic t_region();
      apb(dma_pkg::addr_region_chan_mask, 1'b1, 0);
      apb(dma_pkg::addr_error_enable, 1'b1, 32'h0000_0002);
      load(12'h000, 0, 32'h0000_1000, 32'h0000_2000, 32'h0001_0002, 0, 32'h0000_FFFF);
      apb(dma_pkg::addr_trigger, 1'b1, 1);
      wait_n(0);
      apb(dma_pkg::addr_error_record, 1'b0, 0);
      check("error record", rd & 32'h0000_0002, 32'h0000_0002);
      apb(dma_pkg::addr_error_record, 1'b1, 32'h0000_0002);
      apb(dma_pkg::addr_error_record, 1'b0, 0);
      check("error cleared", rd & 32'h0000_0002, 0);
      $display("done region");
   endtask : t_region
   task automatic results();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      results();
   end
   initial begin
      {psel, penable, pwrite, sync_event, slow} = 5'b00000;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      reset = 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_regs();
      t_rows(1'b0);
      t_rows(1'b1);
      t_fixed();
      t_link(1'b0);
      t_link(1'b1);
      t_chain();
      t_region();
      results();
   end
endmodule : dma_set_memory_a_link_chain_status_tb
